// ===== rtl/rtc_alarm_match_unit.sv
`timescale 1ns/100ps
module rtc_alarm_match_unit
	import alarm_pkg::*;
#(
	parameter logic [7:0] PULSE_TICKS = PULSE_TICKS_DEFAULT
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_second_tick,
	input wire logic [7:0] i_time_seconds,
	input wire logic [7:0] i_time_minutes,
	input wire logic [7:0] i_time_hours,
	input wire logic [7:0] i_time_date,
	input wire logic [7:0] i_time_month,
	input wire logic [7:0] i_time_weekday,
	input wire logic i_interrupt_mode_select,
	input wire logic i_freq_out_enable,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_alarm_flag,
	output logic o_interrupt_or_freq_pin_n
);
	typedef struct packed {
		logic [FIELDS-1:0][7:0] alarm;
		logic auto_clear_on_read;
		logic alarm_flag;
		logic [7:0] rdata;
		logic pin_n;
		pulse_state_t st;
		logic [7:0] cnt;
		logic match_last;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic match;
	logic trigger;
	logic in_alarm;
	logic [2:0] idx;
	logic [FIELDS-1:0][7:0] time_now;
	logic [FIELDS-1:0] alarm_en;
	logic [FIELDS-1:0] field_eq;

	// Weekday is the last field; there is deliberately no year slot
	alarm_field_compare #(.N(FIELDS)) u_cmp (
		.i_alarm_bytes(s_q.alarm),
		.i_time_bytes({i_time_weekday, i_time_month, i_time_date,
			i_time_hours, i_time_minutes, i_time_seconds}),
		.o_match(match)
	);

	// Time inputs already hold the new value in the tick cycle; only the
	// tick that reaches the match fires, so a cleared alarm stays clear
	assign trigger = i_second_tick && match &&
		!s_q.match_last;
	assign in_alarm = (i_reg_addr >= ADDR_ALARM_FIRST) &&
		(i_reg_addr <= ADDR_ALARM_LAST);
	assign idx = 3'(i_reg_addr - ADDR_ALARM_FIRST);

	// Independent per-field view, read only by the checks below
	assign time_now = {i_time_weekday, i_time_month, i_time_date,
		i_time_hours, i_time_minutes, i_time_seconds};
	genvar f;
	generate
		for (f = 0; f < FIELDS; f++) begin : g_chk
			assign alarm_en[f] = s_q.alarm[f][BIT_ENABLE];
			assign field_eq[f] = (s_q.alarm[f][BIT_ENABLE-1:0] ==
				time_now[f][BIT_ENABLE-1:0]);
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		// Match seen at each tick, for edge detection
		if (i_second_tick) begin
			s_d.match_last = match;
		end
		if (i_reg_wr && in_alarm) begin
			s_d.alarm[idx] = i_reg_wdata;
			// New alarm value re-arms even if time already matches it
			s_d.match_last = 1'b0;
		end
		if (i_reg_wr && i_reg_addr == ADDR_STATUS) begin
			s_d.auto_clear_on_read = i_reg_wdata[BIT_AUTO_CLEAR];
			if (!i_reg_wdata[BIT_ALARM_FLAG]) begin
				s_d.alarm_flag = 1'b0;
			end
		end
		s_d.rdata = READ_ZERO;
		if (i_reg_rd && in_alarm) begin
			s_d.rdata = s_q.alarm[idx];
		end
		if (i_reg_rd && i_reg_addr == ADDR_STATUS) begin
			s_d.rdata[BIT_AUTO_CLEAR] = s_q.auto_clear_on_read;
			s_d.rdata[BIT_ALARM_FLAG] = s_q.alarm_flag;
			if (s_q.auto_clear_on_read) begin
				s_d.alarm_flag = 1'b0;
			end
		end
		// Set after the clears so a same-cycle event is never lost
		if (trigger) begin
			s_d.alarm_flag = 1'b1;
		end
		case (s_q.st)
			ST_IDLE: begin
				if (trigger) begin
					s_d.st = ST_PULSE;
					s_d.cnt = PULSE_TICKS;
				end
			end
			ST_PULSE: begin
				if (trigger) begin
					s_d.cnt = PULSE_TICKS;
				end else if (i_second_tick) begin
					if (s_q.cnt <= CNT_ONE) begin
						s_d.st = ST_IDLE;
					end
					s_d.cnt = s_q.cnt - CNT_ONE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// Frequency output owns the pin when enabled
		if (i_freq_out_enable) begin
			s_d.pin_n = 1'b1;
		end else if (i_interrupt_mode_select) begin
			s_d.pin_n = (s_d.st != ST_PULSE);
		end else begin
			s_d.pin_n = !s_d.alarm_flag;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			s_q.alarm <= {FIELDS{ALARM_RESET}};
			s_q.auto_clear_on_read <= 1'b0;
			s_q.alarm_flag <= 1'b0;
			s_q.rdata <= READ_ZERO;
			s_q.pin_n <= 1'b1;
			s_q.st <= ST_IDLE;
			s_q.cnt <= READ_ZERO;
			s_q.match_last <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_reg_rdata = s_q.rdata;
	assign o_alarm_flag = s_q.alarm_flag;
	assign o_interrupt_or_freq_pin_n = s_q.pin_n;

	property p_flag_on_trigger;
		@(posedge i_clk_sys) disable iff (i_rst)
		trigger |=> o_alarm_flag;
	endproperty
	a_flag_on_trigger: assert property (p_flag_on_trigger)
		else $error("flag not set after match");

	property p_flag_needs_trigger;
		@(posedge i_clk_sys) disable iff (i_rst)
		!o_alarm_flag ##1 o_alarm_flag |-> $past(trigger);
	endproperty
	a_flag_needs_trigger: assert property (p_flag_needs_trigger)
		else $error("flag rose without a match");

	property p_single_pin;
		@(posedge i_clk_sys) disable iff (i_rst)
		!i_freq_out_enable && !i_interrupt_mode_select |=>
			(o_interrupt_or_freq_pin_n == !o_alarm_flag);
	endproperty
	a_single_pin: assert property (p_single_pin)
		else $error("single event pin does not follow flag");

	property p_write_clear;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_wr && i_reg_addr == ADDR_STATUS &&
			!i_reg_wdata[BIT_ALARM_FLAG] && !trigger |=> !o_alarm_flag;
	endproperty
	a_write_clear: assert property (p_write_clear)
		else $error("flag survived a zero write");

	property p_read_clear;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_STATUS && s_q.auto_clear_on_read &&
			!trigger |=> !o_alarm_flag;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("auto clear on read failed");

	property p_no_read_clear;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_rd && !i_reg_wr && !s_q.auto_clear_on_read && o_alarm_flag
			|=> o_alarm_flag;
	endproperty
	a_no_read_clear: assert property (p_no_read_clear)
		else $error("flag cleared by read with auto clear off");

	property p_pulse_start;
		@(posedge i_clk_sys) disable iff (i_rst)
		trigger && !i_freq_out_enable && i_interrupt_mode_select |=>
			!o_interrupt_or_freq_pin_n;
	endproperty
	a_pulse_start: assert property (p_pulse_start)
		else $error("periodic pulse missing on match");

	property p_pulse_end;
		@(posedge i_clk_sys) disable iff (i_rst)
		s_q.st == ST_PULSE && s_q.cnt == CNT_ONE && i_second_tick &&
			!trigger |=> s_q.st == ST_IDLE;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("periodic pulse did not end");

	property p_alarm_readback;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_wr && in_alarm ##1 !i_reg_wr ##1 i_reg_rd && !i_reg_wr &&
			i_reg_addr == $past(i_reg_addr, 2) |=>
			o_reg_rdata == $past(i_reg_wdata, 3);
	endproperty
	a_alarm_readback: assert property (p_alarm_readback)
		else $error("alarm byte readback mismatch");

	property p_rdata_idle;
		@(posedge i_clk_sys) disable iff (i_rst)
		!i_reg_rd |=> o_reg_rdata == READ_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data did not return to zero");

	property p_status_readback;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_STATUS |=>
			o_reg_rdata[BIT_ALARM_FLAG] == $past(o_alarm_flag);
	endproperty
	a_status_readback: assert property (p_status_readback)
		else $error("status readback does not show the flag");

	property p_unmapped_read;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_reg_rd && !in_alarm && i_reg_addr != ADDR_STATUS |=>
			o_reg_rdata == READ_ZERO;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped address read nonzero");

	property p_no_stray_write;
		@(posedge i_clk_sys) disable iff (i_rst)
		!(i_reg_wr && in_alarm) |=> s_q.alarm == $past(s_q.alarm);
	endproperty
	a_no_stray_write: assert property (p_no_stray_write)
		else $error("alarm byte changed without a write");

	property p_trigger_fields;
		@(posedge i_clk_sys) disable iff (i_rst)
		trigger |-> &(field_eq | ~alarm_en);
	endproperty
	a_trigger_fields: assert property (p_trigger_fields)
		else $error("match fired with an enabled field unequal");

	property p_trigger_enabled;
		@(posedge i_clk_sys) disable iff (i_rst)
		trigger |-> |alarm_en;
	endproperty
	a_trigger_enabled: assert property (p_trigger_enabled)
		else $error("match fired with no field enabled");

	property p_trigger_reach;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_second_tick && |alarm_en && &(field_eq | ~alarm_en) &&
			!s_q.match_last |-> trigger;
	endproperty
	a_trigger_reach: assert property (p_trigger_reach)
		else $error("time reached the alarm but no match fired");

	property p_flag_holds;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_alarm_flag && !i_reg_wr && !i_reg_rd |=> o_alarm_flag;
	endproperty
	a_flag_holds: assert property (p_flag_holds)
		else $error("alarm flag dropped without host action");

	property p_pulse_hold;
		@(posedge i_clk_sys) disable iff (i_rst)
		s_q.st == ST_PULSE && !i_second_tick && !i_freq_out_enable &&
			i_interrupt_mode_select |=> !o_interrupt_or_freq_pin_n;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold)
		else $error("periodic pulse ended between ticks");

	property p_pulse_idle;
		@(posedge i_clk_sys) disable iff (i_rst)
		s_q.st == ST_IDLE && !trigger && !i_freq_out_enable &&
			i_interrupt_mode_select |=> o_interrupt_or_freq_pin_n;
	endproperty
	a_pulse_idle: assert property (p_pulse_idle)
		else $error("periodic pin low without a pulse");

	property p_freq_owns_pin;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_freq_out_enable |=> o_interrupt_or_freq_pin_n;
	endproperty
	a_freq_owns_pin: assert property (p_freq_owns_pin)
		else $error("alarm drove the pin while frequency output on");
endmodule // rtc_alarm_match_unit

// ===== include/alarm_pkg.sv
package alarm_pkg;
	localparam int FIELDS = 6;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_ALARM_FIRST = 8'h10;
	localparam logic [7:0] ADDR_ALARM_LAST = 8'h15;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_AUTO_CLEAR = 7;
	localparam int BIT_ALARM_FLAG = 4;
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [7:0] PULSE_TICKS_DEFAULT = 8'h01;
	localparam logic [7:0] CNT_ONE = 8'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_PULSE = 2'b10
	} pulse_state_t;
endpackage

// ===== rtl/alarm_field_compare.sv
`timescale 1ns/100ps
module alarm_field_compare
	import alarm_pkg::*;
#(
	parameter int N = FIELDS
) (
	input wire logic [N*8-1:0] i_alarm_bytes,
	input wire logic [N*8-1:0] i_time_bytes,
	output logic o_match
);
	logic [N-1:0] en;
	logic [N-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_field
			// Enable bit sits where the time byte has its top bit; not compared
			assign en[g] = i_alarm_bytes[g*8+BIT_ENABLE];
			assign hit[g] = !en[g] || (i_alarm_bytes[g*8 +: BIT_ENABLE] ==
				i_time_bytes[g*8 +: BIT_ENABLE]);
		end
	endgenerate

	// Any mix of fields; nothing enabled means no alarm at all
	assign o_match = (|en) && (&hit);
endmodule // alarm_field_compare

// ===== dv/host_model.sv
`timescale 1ns/100ps
module host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		// Released lines show junk, not the last value
		o_wdata <= ~d;
		o_addr <= ~a;
		// Let registered outputs settle before the caller looks
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 v = i_rdata;
	endtask
endmodule // host_model

// ===== dv/rtc_alarm_match_unit_tb.sv
`timescale 1ns/100ps
module rtc_alarm_match_unit_tb;
	import alarm_pkg::*;
	logic clk, rst, stk, im, fout, wr, rd, flag, pin_n;
	logic [7:0] sec, min, hr, addr, wdata, rdata, v;
	int error_cnt = 0;
	int n_compared = 0;
	rtc_alarm_match_unit u_rtc_alarm_match_unit (.i_clk_sys(clk),
		.i_rst(rst), .i_second_tick(stk), .i_time_seconds(sec),
		.i_time_minutes(min), .i_time_hours(hr), .i_time_date(8'h01),
		.i_time_month(8'h01), .i_time_weekday(8'h01),
		.i_interrupt_mode_select(im), .i_freq_out_enable(fout),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .o_alarm_flag(flag),
		.o_interrupt_or_freq_pin_n(pin_n));
	host_model u_host_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wr(wr), .o_wdata(wdata), .o_rd(rd));
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		n_compared++;
		if (e !== s) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input logic [7:0] s, input logic [7:0] m);
		@(posedge clk);
		sec <= s;
		min <= m;
		stk <= 1'b1;
		@(posedge clk);
		stk <= 1'b0;
		#1;
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{rst, stk, im, fout, sec, min, hr} = {4'b1000, 24'h000000};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < FIELDS; i++) begin
			u_host_model.rd(ADDR_ALARM_FIRST + 8'(i), v);
			chk("alarm", ALARM_RESET, v);
			u_host_model.wr(ADDR_ALARM_FIRST + 8'(i), 8'hC0 + 8'(i));
			u_host_model.rd(ADDR_ALARM_FIRST + 8'(i), v);
			chk("alarm", 8'hC0 + 8'(i), v);
			u_host_model.wr(ADDR_ALARM_FIRST + 8'(i), 8'h00);
		end
		// No year byte follows the weekday byte
		u_host_model.wr(8'h16, 8'h85);
		u_host_model.rd(8'h16, v);
		chk("addr16", READ_ZERO, v);
		u_host_model.wr(8'h11, 8'hB0);
		u_host_model.wr(8'h12, 8'h91);
		hr <= 8'h11;
		tick(8'h59, 8'h29);
		chk("flag", 8'h00, {7'h00, flag});
		tick(8'h00, 8'h30);
		chk("flag", 8'h01, {7'h00, flag});
		tick(8'h01, 8'h31);
		chk("pin", 8'h00, {7'h00, pin_n});
		u_host_model.wr(ADDR_STATUS, 8'h00);
		chk("pin", 8'h01, {7'h00, pin_n});
		hr <= 8'h10;
		tick(8'h00, 8'h30);
		chk("flag", 8'h00, {7'h00, flag});
		hr <= 8'h11;
		u_host_model.wr(ADDR_STATUS, 8'h80);
		tick(8'h00, 8'h30);
		u_host_model.rd(ADDR_STATUS, v);
		chk("status", 8'h90, v);
		u_host_model.rd(ADDR_STATUS, v);
		chk("status", 8'h80, v);
		u_host_model.wr(8'h11, 8'h00);
		u_host_model.wr(8'h12, 8'h00);
		u_host_model.wr(8'h10, 8'hB0);
		im <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			tick(8'h30, 8'h05);
			chk("pin", 8'h00, {7'h00, pin_n});
			tick(8'h31, 8'h05);
			chk("pin", 8'h01, {7'h00, pin_n});
			chk("flag", 8'h01, {7'h00, flag});
			// Cleared flag must come back on the next periodic match
			u_host_model.wr(ADDR_STATUS, 8'h00);
			chk("flag", 8'h00, {7'h00, flag});
		end
		// Minutes-only single event: one match per reach, not per second
		im <= 1'b0;
		u_host_model.wr(8'h10, 8'h00);
		u_host_model.wr(8'h11, 8'hB0);
		tick(8'h00, 8'h30);
		u_host_model.rd(ADDR_STATUS, v);
		chk("status", 8'h10, v);
		u_host_model.wr(ADDR_STATUS, 8'h00);
		tick(8'h01, 8'h30);
		chk("flag", 8'h00, {7'h00, flag});
		chk("pin", 8'h01, {7'h00, pin_n});
		fout <= 1'b1;
		tick(8'h00, 8'h31);
		tick(8'h00, 8'h30);
		chk("flag", 8'h01, {7'h00, flag});
		chk("pin", 8'h01, {7'h00, pin_n});
		end_of_test();
	end
endmodule // rtc_alarm_match_unit_tb
